// File: hdl/ppacir_top.sv
// Contract
// - pull-up on: global on, input direction, pin bit set, not analog
// - port B pull-up bits 7-4 and 1, read/write, reset to 1
// - unimplemented bits read zero, writes ignored; direction registers reset them to 1
// - port B analog select bits 6-4 and 1, reset to 1
// - analog pin: digital input, pull-up, change detect disabled
// - per-pin change enables, reset to 0
// - port A pin 5 change detect off when master clear selected
// - enabled pins compare to last-read latch; mismatches ORed to flag
// - flag sets regardless of irq enable; irq only when enabled
// - port A enables bits 7-5,3-0; port B 7-4,1-0
// - mismatch keeps flag set; port access ends mismatch, then clear
// - last-read latch survives master-clear reset
// - change coinciding with port access may be missed
// - detected change wakes from sleep when irq enabled
`include "ppacir_map.svh"
module ppacir_top
(
   // clock and resets
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic MASTER_CLEAR_PIN_RST,
   // axi4-lite slave
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // port pins
   input wire logic [7:0] PORTA_PIN_IN,
   input wire logic [7:0] PORTB_PIN_IN,
   output logic [7:0] PORTB_PULLUP_ON,
   output logic [7:0] PORTA_DIG_IN_EN,
   output logic [7:0] PORTB_DIG_IN_EN,
   // interrupt and sleep
   input wire logic SLEEP_MODE,
   output logic CHANGE_IRQ,
   output logic WAKE_REQ,
   output logic IRQ_OUT
);
   // ==========================================================
   // bus state
   ppacir_pkg::ppacir_state_e state_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [31:0] rdata_reg;
   logic resp_err_reg;
   // ==========================================================
   // registers
   ppacir_pkg::ppacir_byte_t pb_pullup_reg;
   ppacir_pkg::ppacir_byte_t pb_analog_reg;
   ppacir_pkg::ppacir_byte_t pa_analog_reg;
   ppacir_pkg::ppacir_byte_t options_reg;
   ppacir_pkg::ppacir_byte_t pa_data_reg;
   ppacir_pkg::ppacir_byte_t pb_data_reg;
   ppacir_pkg::ppacir_byte_t pa_dir_reg;
   ppacir_pkg::ppacir_byte_t pb_dir_reg;
   ppacir_pkg::ppacir_byte_t pa_chg_en_reg;
   ppacir_pkg::ppacir_byte_t pb_chg_en_reg;
   logic irq_en_reg;
   logic change_flag_reg;
   logic master_clear_pin_func_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic mismatch_d_reg;
   ppacir_pkg::ppacir_byte_t pa_last_reg;
   ppacir_pkg::ppacir_byte_t pb_last_reg;
   ppacir_pkg::ppacir_byte_t pa_s1_reg;
   ppacir_pkg::ppacir_byte_t pa_s2_reg;
   ppacir_pkg::ppacir_byte_t pb_s1_reg;
   ppacir_pkg::ppacir_byte_t pb_s2_reg;
   // ==========================================================
   // internal nets
   logic do_write;
   logic do_read;
   logic port_access;
   logic mismatch;
   logic flag_clear;
   logic status_read;
   ppacir_pkg::ppacir_byte_t pa_in;
   ppacir_pkg::ppacir_byte_t pb_in;
   ppacir_pkg::ppacir_byte_t pa_chg_eff;
   ppacir_pkg::ppacir_byte_t pb_chg_eff;
   ppacir_pkg::ppacir_byte_t wbyte;
   logic [31:0] rdata_next;
   logic rerr_next;
   logic werr;

   assign wbyte = w_data_reg[7:0];
   assign do_write = (state_reg == ppacir_pkg::PPACIR_IDLE) && aw_have_reg
      && w_have_reg && w_strb_reg[0];
   assign do_read = (state_reg == ppacir_pkg::PPACIR_IDLE) && S_AXI_ARVALID
      && !(aw_have_reg && w_have_reg);
   // ==========================================================
   // axi handshakes
   assign S_AXI_AWREADY = !aw_have_reg;
   assign S_AXI_WREADY = !w_have_reg;
   assign S_AXI_ARREADY = do_read;
   assign S_AXI_BVALID = (state_reg == ppacir_pkg::PPACIR_WRESP);
   assign S_AXI_RVALID = (state_reg == ppacir_pkg::PPACIR_RRESP);
   assign S_AXI_BRESP = resp_err_reg ? 2'h2 : 2'h0;
   assign S_AXI_RRESP = resp_err_reg ? 2'h2 : 2'h0;
   assign S_AXI_RDATA = rdata_reg;

   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end
      else if (S_AXI_AWVALID && !aw_have_reg)
      begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= S_AXI_AWADDR;
      end
      else if (state_reg == ppacir_pkg::PPACIR_IDLE && aw_have_reg
         && w_have_reg)
      begin
         aw_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end
      else if (S_AXI_WVALID && !w_have_reg)
      begin
         w_have_reg <= 1'b1;
         w_data_reg <= S_AXI_WDATA;
         w_strb_reg <= S_AXI_WSTRB;
      end
      else if (state_reg == ppacir_pkg::PPACIR_IDLE && aw_have_reg
         && w_have_reg)
      begin
         w_have_reg <= 1'b0;
      end
   end

   // write address decode for error answer
   always_comb
   begin
      werr = 1'b0;
      if (aw_addr_reg[1:0] != 2'b00)
      begin
         werr = 1'b1;
      end
      else if (aw_addr_reg > `PPACIR_OFS_CONFIG)
      begin
         werr = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state_reg <= ppacir_pkg::PPACIR_IDLE;
         resp_err_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         case (state_reg)
            ppacir_pkg::PPACIR_IDLE:
            begin
               if (aw_have_reg && w_have_reg)
               begin
                  state_reg <= ppacir_pkg::PPACIR_WRESP;
                  resp_err_reg <= werr;
               end
               else if (S_AXI_ARVALID)
               begin
                  state_reg <= ppacir_pkg::PPACIR_RRESP;
                  resp_err_reg <= rerr_next;
                  rdata_reg <= rdata_next;
               end
            end
            ppacir_pkg::PPACIR_WRESP:
            begin
               if (S_AXI_BREADY)
               begin
                  state_reg <= ppacir_pkg::PPACIR_IDLE;
               end
            end
            ppacir_pkg::PPACIR_RRESP:
            begin
               if (S_AXI_RREADY)
               begin
                  state_reg <= ppacir_pkg::PPACIR_IDLE;
               end
            end
            default:
            begin
               state_reg <= ppacir_pkg::PPACIR_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // read decode
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      rerr_next = 1'b0;
      if (S_AXI_ARADDR == `PPACIR_OFS_PB_PULLUP)
         rdata_next[7:0] = pb_pullup_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_PB_ANALOG)
         rdata_next[7:0] = pb_analog_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_OPTIONS)
         rdata_next[7:0] = options_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_PA_DATA)
         rdata_next[7:0] = pa_in & ~pa_analog_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_PB_DATA)
         rdata_next[7:0] = pb_in & ~pb_analog_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_PA_DIR)
         rdata_next[7:0] = pa_dir_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_PB_DIR)
         rdata_next[7:0] = pb_dir_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_PA_CHG_EN)
         rdata_next[7:0] = pa_chg_en_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_PB_CHG_EN)
         rdata_next[7:0] = pb_chg_en_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_PA_ANALOG)
         rdata_next[7:0] = pa_analog_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_INT_CTRL)
      begin
         rdata_next[`PPACIR_IRQ_EN_BIT] = irq_en_reg;
         rdata_next[`PPACIR_FLAG_BIT] = change_flag_reg;
      end
      else if (S_AXI_ARADDR == `PPACIR_OFS_IRQ_STATUS)
         rdata_next[1:0] = irq_status_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_IRQ_MASK)
         rdata_next[1:0] = irq_mask_reg;
      else if (S_AXI_ARADDR == `PPACIR_OFS_CONFIG)
         rdata_next[`PPACIR_MASTER_CLEAR_PIN_BIT] = master_clear_pin_func_reg;
      else
         rerr_next = 1'b1;
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         pb_pullup_reg <= `PPACIR_PB_PULLUP_RST;
         pb_analog_reg <= `PPACIR_PB_ANALOG_RST;
         pa_analog_reg <= `PPACIR_PA_ANALOG_RST;
         options_reg <= `PPACIR_OPTIONS_RST;
         pa_dir_reg <= `PPACIR_DIR_RST;
         pb_dir_reg <= `PPACIR_DIR_RST;
         pa_data_reg <= 8'h00;
         pb_data_reg <= 8'h00;
         pa_chg_en_reg <= 8'h00;
         pb_chg_en_reg <= 8'h00;
         irq_en_reg <= 1'b0;
         master_clear_pin_func_reg <= 1'b0;
      end
      else if (do_write)
      begin
         if (aw_addr_reg == `PPACIR_OFS_PB_PULLUP)
            pb_pullup_reg <= wbyte & `PPACIR_PB_PULLUP_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_PB_ANALOG)
            pb_analog_reg <= wbyte & `PPACIR_PB_ANALOG_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_PA_ANALOG)
            pa_analog_reg <= wbyte & `PPACIR_PA_ANALOG_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_OPTIONS)
            options_reg <= wbyte;
         else if (aw_addr_reg == `PPACIR_OFS_PA_DIR)
            pa_dir_reg <= wbyte & `PPACIR_PA_PIN_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_PB_DIR)
            pb_dir_reg <= wbyte & `PPACIR_PB_PIN_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_PA_DATA)
            pa_data_reg <= wbyte & `PPACIR_PA_PIN_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_PB_DATA)
            pb_data_reg <= wbyte & `PPACIR_PB_PIN_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_PA_CHG_EN)
            pa_chg_en_reg <= wbyte & `PPACIR_PA_CHG_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_PB_CHG_EN)
            pb_chg_en_reg <= wbyte & `PPACIR_PB_CHG_MASK;
         else if (aw_addr_reg == `PPACIR_OFS_INT_CTRL)
            irq_en_reg <= wbyte[`PPACIR_IRQ_EN_BIT];
         else if (aw_addr_reg == `PPACIR_OFS_CONFIG)
            master_clear_pin_func_reg <= wbyte[`PPACIR_MASTER_CLEAR_PIN_BIT];
      end
   end

   // ==========================================================
   // pin synchroniser
   // two-stage synchroniser
   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         pa_s1_reg <= 8'h00;
         pa_s2_reg <= 8'h00;
         pb_s1_reg <= 8'h00;
         pb_s2_reg <= 8'h00;
      end
      else
      begin
         pa_s1_reg <= PORTA_PIN_IN;
         pa_s2_reg <= pa_s1_reg;
         pb_s1_reg <= PORTB_PIN_IN;
         pb_s2_reg <= pb_s1_reg;
      end
   end

   assign pa_in = pa_s2_reg & `PPACIR_PA_PIN_MASK;
   assign pb_in = pb_s2_reg & `PPACIR_PB_PIN_MASK;
   assign PORTA_DIG_IN_EN = `PPACIR_PA_PIN_MASK & ~pa_analog_reg;
   assign PORTB_DIG_IN_EN = `PPACIR_PB_PIN_MASK & ~pb_analog_reg;

   assign PORTB_PULLUP_ON = pb_pullup_reg & pb_dir_reg & ~pb_analog_reg
      & {8{options_reg[`PPACIR_GLOBAL_PU_BIT]}};

   // ==========================================================
   // change detection
   // pin 5 suppressed under master clear
   always_comb
   begin
      pa_chg_eff = pa_chg_en_reg & ~pa_analog_reg;
      if (master_clear_pin_func_reg)
         pa_chg_eff[`PPACIR_PIN5] = 1'b0;
   end
   assign pb_chg_eff = pb_chg_en_reg & ~pb_analog_reg;

   assign port_access = (do_write && (aw_addr_reg == `PPACIR_OFS_PA_DATA
      || aw_addr_reg == `PPACIR_OFS_PB_DATA))
      || (do_read && (S_AXI_ARADDR == `PPACIR_OFS_PA_DATA
      || S_AXI_ARADDR == `PPACIR_OFS_PB_DATA));

   assign mismatch = |((pa_in ^ pa_last_reg) & pa_chg_eff)
      | |((pb_in ^ pb_last_reg) & pb_chg_eff);

   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         pa_last_reg <= 8'h00;
         pb_last_reg <= 8'h00;
      end
      else if (port_access)
      begin
         pa_last_reg <= pa_in;
         pb_last_reg <= pb_in;
      end
   end

   assign flag_clear = do_write && aw_addr_reg == `PPACIR_OFS_INT_CTRL
      && !wbyte[`PPACIR_FLAG_BIT];

   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         change_flag_reg <= 1'b0;
      else if (mismatch && !port_access)
         change_flag_reg <= 1'b1;
      else if (flag_clear || MASTER_CLEAR_PIN_RST)
         change_flag_reg <= 1'b0;
   end

   assign CHANGE_IRQ = change_flag_reg && irq_en_reg;
   assign WAKE_REQ = change_flag_reg && irq_en_reg && SLEEP_MODE;

   // ==========================================================
   // interrupt status
   assign status_read = do_read && S_AXI_ARADDR == `PPACIR_OFS_IRQ_STATUS;
   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         irq_status_reg <= 2'b00;
         irq_mask_reg <= 2'b00;
         mismatch_d_reg <= 1'b0;
      end
      else
      begin
         mismatch_d_reg <= mismatch;
         irq_status_reg[0] <= (mismatch && !mismatch_d_reg)
            || (irq_status_reg[0] && !status_read);
         irq_status_reg[1] <= (flag_clear && change_flag_reg)
            || (irq_status_reg[1] && !status_read);
         if (do_write && aw_addr_reg == `PPACIR_OFS_IRQ_MASK)
            irq_mask_reg <= wbyte[1:0];
      end
   end
   assign IRQ_OUT = |(irq_status_reg & irq_mask_reg);
endmodule

// File: shared/ppacir_map.svh
`ifndef PPACIR_MAP_SVH
`define PPACIR_MAP_SVH
// ==========================================================
// register byte offsets
`define PPACIR_OFS_PB_PULLUP 8'h00
`define PPACIR_OFS_PB_ANALOG 8'h04
`define PPACIR_OFS_OPTIONS 8'h08
`define PPACIR_OFS_PA_DATA 8'h0C
`define PPACIR_OFS_PB_DATA 8'h10
`define PPACIR_OFS_PA_DIR 8'h14
`define PPACIR_OFS_PB_DIR 8'h18
`define PPACIR_OFS_PA_CHG_EN 8'h1C
`define PPACIR_OFS_PB_CHG_EN 8'h20
`define PPACIR_OFS_PA_ANALOG 8'h24
`define PPACIR_OFS_INT_CTRL 8'h28
`define PPACIR_OFS_IRQ_STATUS 8'h2C
`define PPACIR_OFS_IRQ_MASK 8'h30
`define PPACIR_OFS_CONFIG 8'h34
// ==========================================================
// implemented-bit masks
`define PPACIR_PB_PULLUP_MASK 8'hF2
`define PPACIR_PB_ANALOG_MASK 8'h72
`define PPACIR_PA_ANALOG_MASK 8'h0F
`define PPACIR_PA_CHG_MASK 8'hEF
`define PPACIR_PB_CHG_MASK 8'hF3
`define PPACIR_PA_PIN_MASK 8'hEF
`define PPACIR_PB_PIN_MASK 8'hF3
// ==========================================================
// reset values
`define PPACIR_PB_PULLUP_RST 8'hF2
`define PPACIR_PB_ANALOG_RST 8'h72
`define PPACIR_PA_ANALOG_RST 8'h0F
`define PPACIR_DIR_RST 8'hFF
`define PPACIR_OPTIONS_RST 8'h80
// ==========================================================
// field positions
`define PPACIR_GLOBAL_PU_BIT 7
`define PPACIR_IRQ_EN_BIT 3
`define PPACIR_FLAG_BIT 0
`define PPACIR_MASTER_CLEAR_PIN_BIT 0
`define PPACIR_PIN5 5
`endif

// File: shared/ppacir_pkg.sv
package ppacir_pkg;
   typedef logic [7:0] ppacir_byte_t;
   typedef enum logic [2:0]
   {
      PPACIR_IDLE = 3'b001,
      PPACIR_WRESP = 3'b010,
      PPACIR_RRESP = 3'b100
   } ppacir_state_e;
endpackage

// File: verification/ppacir_properties.sv
// ==========================================================
// port checker
module ppacir_props
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // register bus
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // pins and interrupt
   input wire logic [7:0] PORTB_PULLUP_ON,
   input wire logic [7:0] PORTB_DIG_IN_EN,
   input wire logic SLEEP_MODE,
   input wire logic CHANGE_IRQ,
   input wire logic WAKE_REQ
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   sequence wr_pair_s;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence rd_take_s;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   // ==========================================================
   // pins
   // wake gating
   wake_gate_a: assert property (WAKE_REQ == (CHANGE_IRQ && SLEEP_MODE))
      else $error("wake request not irq and sleep");
   pullup_analog_a: assert property ((PORTB_PULLUP_ON & ~PORTB_DIG_IN_EN) == 0)
      else $error("pull-up on an analog pin");
   pullup_bits_a: assert property ((PORTB_PULLUP_ON & 8'h0D) == 8'h00)
      else $error("pull-up on a pin without enable bit");
   // ==========================================================
   // register bus
   bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
      |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   read_answer_a: assert property (rd_take_s |=> S_AXI_RVALID)
      else $error("read answer late");
   write_answer_a: assert property (wr_pair_s |-> ##[1:2] S_AXI_BVALID)
      else $error("write answer late");
   rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 0)
      else $error("upper read bits not zero");
endmodule
bind ppacir_top ppacir_props i_props
(
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .PORTB_PULLUP_ON(PORTB_PULLUP_ON),
   .PORTB_DIG_IN_EN(PORTB_DIG_IN_EN), .SLEEP_MODE(SLEEP_MODE),
   .CHANGE_IRQ(CHANGE_IRQ), .WAKE_REQ(WAKE_REQ)
);

// File: verification/ppacir_pin_model.sv
// ==========================================================
// external pin drivers
module ppacir_pin_model
(
   // clock
   input wire logic clk,
   // commanded levels
   input wire logic [7:0] a_level,
   input wire logic [7:0] b_level,
   input wire logic [7:0] b_drive,
   // device side
   input wire logic [7:0] pullup_on,
   output logic [7:0] pin_a,
   output logic [7:0] pin_b
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] float_q = 8'h00;
   // released pins without pull-up wander each cycle
   always_ff @(posedge clk)
   begin
      float_q <= ~pin_b;
   end
   assign pin_a = a_level;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         pin_b[i] = b_drive[i] ? b_level[i] : (pullup_on[i] | float_q[i]);
      end
   end
endmodule

// File: verification/test_port_pullup_analog_change_irq.sv
`include "ppacir_map.svh"
module test_port_pullup_analog_change_irq;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;
      logic [1:0] r;} ppacir_row_s;
   logic clk, rst, master_clear_pin, sleep, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq, wake, irq_out;
   logic [7:0] awaddr, araddr, pa, pb, pu, dina, dinb, pin_a, pin_b;
   logic [31:0] wdata, rdata, rd_q;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, br_q, rr_q;
   int failures = 0;
   int compares = 0;
   ppacir_row_s rows [13] = '{'{8'h00, 0, 8'h00, 8'hF2, 0},
      '{8'h04, 0, 8'h00, 8'h72, 0}, '{8'h1C, 0, 8'h00, 8'h00, 0},
      '{8'h20, 0, 8'h00, 8'h00, 0}, '{8'h00, 1, 8'hFF, 8'hF2, 0},
      '{8'h04, 1, 8'hFF, 8'h72, 0}, '{8'h1C, 1, 8'hFF, 8'hEF, 0},
      '{8'h20, 1, 8'hFF, 8'hF3, 0}, '{8'h3C, 1, 8'hFF, 8'h00, 2},
      '{8'h04, 1, 8'h00, 8'h00, 0}, '{8'h24, 1, 8'h00, 8'h00, 0},
      '{8'h1C, 1, 8'h00, 8'h00, 0}, '{8'h20, 1, 8'h00, 8'h00, 0}};
   ppacir_top i_dut
   (
      .REF_CLK(clk), .SYS_RST(rst), .MASTER_CLEAR_PIN_RST(master_clear_pin),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .PORTA_PIN_IN(pin_a), .PORTB_PIN_IN(pin_b), .PORTB_PULLUP_ON(pu),
      .PORTA_DIG_IN_EN(dina), .PORTB_DIG_IN_EN(dinb),
      .SLEEP_MODE(sleep), .CHANGE_IRQ(irq), .WAKE_REQ(wake), .IRQ_OUT(irq_out)
   );
   ppacir_pin_model i_pins
   (
      .clk(clk), .a_level(pa), .b_level(pb), .b_drive(8'h7F),
      .pullup_on(pu), .pin_a(pin_a), .pin_b(pin_b)
   );
   // ==========================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [7:0] d);
      logic [2:0] p;
      logic [2:0] t;
      @(posedge clk);
      p = 3'b111;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (p != 3'b000)
      begin
         @(negedge clk);
         t = p & {awready, wready, bvalid};
         if (t[0]) br_q = bresp;
         @(posedge clk);
         if (t[2]) awvalid <= 1'b0;
         if (t[1]) wvalid <= 1'b0;
         if (t[0]) bready <= 1'b0;
         p = p & ~t;
      end
   endtask
   task automatic axr(input logic [7:0] a);
      logic [1:0] p;
      logic [1:0] t;
      @(posedge clk);
      p = 2'b11;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (p != 2'b00)
      begin
         @(negedge clk);
         t = p & {arready, rvalid};
         if (t[0]) rd_q = rdata;
         if (t[0]) rr_q = rresp;
         @(posedge clk);
         if (t[1]) arvalid <= 1'b0;
         if (t[0]) rready <= 1'b0;
         p = p & ~t;
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic pin(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk);
      pa <= a;
      pb <= b;
   endtask
   task automatic flag_is(input logic [7:0] e);
      settle(4);
      axr(`PPACIR_OFS_INT_CTRL);
      chk("flag_read", rd_q & 8'h01, e);
   endtask
   task automatic finish_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================================
   // clock, watchdog, sequence
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      finish_test();
   end
   initial
   begin
      {rst, master_clear_pin, sleep, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
      {awaddr, araddr, pa, pb} = 32'h0000_0000;
      wdata = 32'h0000_0000;
      wstrb = 4'h1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("pullup", pu, 8'h80);
      chk("dig_a", dina, 8'hE0);
      chk("dig_b", dinb, 8'h81);
      foreach (rows[i])
      begin
         if (rows[i].w) axw(rows[i].a, rows[i].d);
         if (rows[i].w) chk("bresp", br_q, rows[i].r);
         axr(rows[i].a);
         chk("rresp", rr_q, rows[i].r);
         if (rows[i].r == 2'b00) chk("rdata", rd_q, rows[i].e);
      end
      settle(1);
      chk("pullup", pu, 8'hF2);
      axw(`PPACIR_OFS_PB_DIR, 8'h0F);
      settle(1);
      chk("pullup", pu, 8'h02);
      axw(`PPACIR_OFS_OPTIONS, 8'h00);
      settle(1);
      chk("pullup", pu, 8'h00);
      axw(`PPACIR_OFS_OPTIONS, 8'h80);
      axw(`PPACIR_OFS_PB_DIR, 8'hFF);
      axw(`PPACIR_OFS_PB_ANALOG, 8'h12);
      settle(1);
      chk("pullup", pu, 8'hE0);
      chk("dig_b", dinb, 8'hE1);
      axw(`PPACIR_OFS_PB_ANALOG, 8'h00);
      axr(`PPACIR_OFS_PB_DATA);
      chk("pb_data", rd_q, 8'h80);
      axr(`PPACIR_OFS_PA_DATA);
      axw(`PPACIR_OFS_INT_CTRL, 8'h08);
      axw(`PPACIR_OFS_PA_CHG_EN, 8'hEF);
      axw(`PPACIR_OFS_IRQ_MASK, 8'h01);
      sleep <= 1'b1;
      pin(8'h01, 8'h00);
      settle(1);
      chk("irq_early", irq, 1'b0);
      settle(3);
      chk("irq", irq, 1'b1);
      chk("wake", wake, 1'b1);
      chk("irq_out", irq_out, 1'b1);
      axw(`PPACIR_OFS_INT_CTRL, 8'h08);
      settle(2);
      chk("irq_kept", irq, 1'b1);
      axr(`PPACIR_OFS_PA_DATA);
      chk("pa_data", rd_q, 8'h01);
      axw(`PPACIR_OFS_INT_CTRL, 8'h08);
      settle(2);
      chk("irq_clr", irq, 1'b0);
      axr(`PPACIR_OFS_IRQ_STATUS);
      axr(`PPACIR_OFS_IRQ_STATUS);
      chk("status", rd_q, 8'h00);
      settle(1);
      chk("irq_out", irq_out, 1'b0);
      axw(`PPACIR_OFS_INT_CTRL, 8'h00);
      pin(8'h00, 8'h00);
      flag_is(8'h01);
      chk("irq_off", irq, 1'b0);
      chk("flag", rd_q & 8'h09, 8'h01);
      @(posedge clk);
      master_clear_pin <= 1'b1;
      @(posedge clk);
      master_clear_pin <= 1'b0;
      flag_is(8'h01);
      chk("flag_master_clear_pin", rd_q & 8'h09, 8'h01);
      axr(`PPACIR_OFS_PA_DATA);
      axw(`PPACIR_OFS_INT_CTRL, 8'h00);
      axw(`PPACIR_OFS_CONFIG, 8'h01);
      pin(8'h20, 8'h03);
      flag_is(8'h00);
      chk("flag_pin5", rd_q & 8'h09, 8'h00);
      axw(`PPACIR_OFS_CONFIG, 8'h00);
      flag_is(8'h01);
      chk("flag_pin5", rd_q & 8'h09, 8'h01);
      axr(`PPACIR_OFS_PA_DATA);
      axw(`PPACIR_OFS_INT_CTRL, 8'h00);
      axw(`PPACIR_OFS_PA_ANALOG, 8'h01);
      pin(8'h21, 8'h03);
      flag_is(8'h00);
      chk("flag_ana", rd_q & 8'h09, 8'h00);
      axr(`PPACIR_OFS_PA_DATA);
      chk("pa_ana", rd_q, 8'h20);
      finish_test();
   end
endmodule
